/* File: sleep_pkg.sv */
// shared constants for the sleep state control block
package sleep_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int TYPE_W = 3;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL_A = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CTRL_B = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_MASK = 4'hc;
  // control register fields
  localparam int TYPE_LSB = 10;
  localparam int ENABLE_BIT = 13;
  // status and mask bit positions
  localparam int ST_WAKE = 0;
  localparam int ST_SLEPT = 1;
  localparam int ST_FW_HIB = 2;
  localparam int ST_W = 3;
  // sleep type codes for the two lightest states (context kept)
  localparam logic [TYPE_W-1:0] TYPE_WORKING = 3'h0;
  localparam logic [TYPE_W-1:0] TYPE_LIGHT = 3'h1;
  // sequencing delay in cycles between steps
  localparam logic [7:0] STEP_CYCLES = 8'h04;
endpackage

/* File: sleep_state_control.sv */
// sleep state entry control with avalon-mm register slave
// Overview of operation
// - 3-bit sleep type selects target state
// - enable bit starts sleep using type
// - type and enable accepted in one write
// - two control instances, each own type
// - wake status set by hardware in sleep
// - only enabled wake sources wake system
// - lightest state keeps all context
// - no sequencing on prepare-to-sleep
// - controller sequences planes on enable set
// - processors halted, devices idle in sleep
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
// register map, one 32-bit word per offset
//   ctrl a  : sleep type in the type field, trigger in the enable bit
//   ctrl b  : same layout, the second instance on its own i/o region
//   status  : bit 0 wake, bit 1 sleep entered, bit 2 firmware hibernate
//   mask    : same layout as status, gates the interrupt
// the trigger bit is never stored, so a control word read back and
// written again later cannot start a second sleep by accident
// either control instance may carry the trigger; the sequence always
// follows instance a's type, since b only holds the second constant
// a deep type walks halt, clocks off, memory self-refresh, power off
// and then rests asleep; the light type goes from halt straight to rest
// and keeps clocks, memory and context alive the whole time
// every step dwells for the package step count plus its entry cycle, so
// the plane controls change in a fixed order an outside controller can
// follow without a handshake
// control writes are refused while asleep, so a stray write cannot
// change the type under a running sequence
// limitations: prepare-to-sleep is accepted but never acted on, since it
// may come long before the real trigger; only the enabled wake inputs
// can end a rest, and a wake that comes during the entry steps is only
// acted on once the rest state is reached
module sleep_state_control #(
  parameter int N_WAKE = 8,
  parameter logic [7:0] HIB_REQ_VALUE = 8'h5a // firmware hibernate request code
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [sleep_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [sleep_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [sleep_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cmd_port_write,
  input wire logic [7:0] cmd_port_data,
  input wire logic prepare_to_sleep,
  input wire logic [N_WAKE-1:0] wake_enable,
  input wire logic [N_WAKE-1:0] wake_source,
  output logic [sleep_pkg::TYPE_W-1:0] target_type_a,
  output logic [sleep_pkg::TYPE_W-1:0] target_type_b,
  output logic cpu_halt,
  output logic clocks_stop,
  output logic mem_self_refresh,
  output logic power_off,
  output logic context_keep,
  output logic fw_hibernate,
  output logic sleeping,
  output logic irq
);
  typedef enum logic [2:0] {WORKING, HALT, CLK_OFF, MEM_SR, PWR_OFF, ASLEEP, RESUME} state_e;

  state_e state_r;
  state_e state_nxt;
  logic [sleep_pkg::TYPE_W-1:0] type_a_r; // instance a sleep type
  logic [sleep_pkg::TYPE_W-1:0] type_b_r; // instance b sleep type
  logic [sleep_pkg::ST_W-1:0] status_r; // sticky events
  logic [sleep_pkg::ST_W-1:0] mask_r; // interrupt mask
  logic [sleep_pkg::ST_W-1:0] events;
  logic [7:0] step_r; // step delay counter
  logic [sleep_pkg::DATA_W-1:0] rdata_r;
  logic rd_ack_r; // one wait cycle on reads
  logic [N_WAKE-1:0] wake_sync_q;
  logic hib_pulse;
  logic [sleep_pkg::DATA_W-1:0] rd_mux; // word chosen for the next read

  // true for the type code that keeps all context; shared by the stored
  // type and by the type being written in this cycle
  function automatic logic is_light(input logic [sleep_pkg::TYPE_W-1:0] t);
    return t == sleep_pkg::TYPE_LIGHT;
  endfunction

  // decode; one word per offset, byte lanes gate the writes
  // the control words need lane one, which holds the type and trigger
  wire sel_a = avs_address == sleep_pkg::OFF_CTRL_A;
  wire sel_b = avs_address == sleep_pkg::OFF_CTRL_B;
  wire sel_st = avs_address == sleep_pkg::OFF_STATUS;
  wire sel_mk = avs_address == sleep_pkg::OFF_MASK;
  wire be_hi = avs_byteenable[1];
  wire wr_a = avs_write && sel_a && be_hi && !sleeping;
  wire wr_b = avs_write && sel_b && be_hi && !sleeping;
  wire wr_mk = avs_write && sel_mk && avs_byteenable[0];
  wire [sleep_pkg::TYPE_W-1:0] wr_type =
    avs_writedata[sleep_pkg::TYPE_LSB +: sleep_pkg::TYPE_W];
  // enable and type come from the same write beat on either instance
  wire sleep_go = (wr_a || wr_b) && avs_writedata[sleep_pkg::ENABLE_BIT];
  // only enabled and synchronised wake sources count
  wire wake_hit = |(wake_sync_q & wake_enable);
  wire step_done = step_r == '0;
  wire rd_done = avs_read && rd_ack_r;
  wire st_rd = rd_done && sel_st;
  // type the sequence will follow once this cycle's write lands
  wire [sleep_pkg::TYPE_W-1:0] type_a_nxt = wr_a ? wr_type : type_a_r;
  wire light = is_light(type_a_r);
  // plane controls look ahead, so the very first sleeping cycle already
  // shows the context policy of instance a's type, even one written with the trigger
  wire light_nxt = is_light(type_a_nxt);

  assign hib_pulse = cmd_port_write && (cmd_port_data == HIB_REQ_VALUE) && !sleeping;

  // wake inputs come from other domains; the filter costs three to four
  // cycles of wake latency, but a one-cycle glitch can never end a sleep
  wake_sync #(
    .W(N_WAKE)
  ) u_wake_sync (
    .mclk(mclk),
    .reset(reset),
    .din(wake_source),
    .dout(wake_sync_q)
  );

  // control instances; enable bit is never stored
  // each instance keeps only its own type, so software may load b
  // first and then a together with the trigger
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      type_a_r <= sleep_pkg::TYPE_WORKING;
      type_b_r <= sleep_pkg::TYPE_WORKING;
    end
    else
    begin
      if (wr_a)
        type_a_r <= wr_type;
      if (wr_b)
        type_b_r <= wr_type;
    end
  end

  // sequencer next state; prepare_to_sleep is deliberately ignored, it
  // may arrive seconds ahead of the real trigger
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      // awake; waits for a trigger write
      WORKING:
        if (sleep_go)
          state_nxt = HALT;
      // processor stopped; light type rests from here
      HALT:
        if (step_done)
          state_nxt = light ? ASLEEP : CLK_OFF;
      // clocks stopped before memory is handed over
      CLK_OFF:
        if (step_done)
          state_nxt = MEM_SR;
      // memory refreshes itself before power goes
      MEM_SR:
        if (step_done)
          state_nxt = PWR_OFF;
      // planes off, then rest
      PWR_OFF:
        if (step_done)
          state_nxt = ASLEEP;
      // rest; only an enabled, filtered wake leaves
      ASLEEP:
        if (wake_hit)
          state_nxt = RESUME;
      // planes come back over one dwell
      RESUME:
        if (step_done)
          state_nxt = WORKING;
      default:
        state_nxt = WORKING;
    endcase
  end

  // state register and step counter; the counter reloads on every change
  // of state, so each step lasts the step count plus its entry cycle
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_r <= WORKING;
      step_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt != state_r)
        step_r <= sleep_pkg::STEP_CYCLES;
      else if (!step_done)
        step_r <= step_r - 8'h01;
    end
  end

  // next plane controls; each is held while at or past its step
  wire cpu_halt_nxt = state_nxt != WORKING && state_nxt != RESUME;
  wire deep_rest = state_nxt == ASLEEP && !light_nxt; // deep type at rest
  // processor clocks stop from the clock step on, never for the light type
  wire clocks_stop_nxt = state_nxt inside {CLK_OFF, MEM_SR, PWR_OFF} || deep_rest;
  // memory keeps itself refreshed once the clocks are gone
  wire mem_sr_nxt = state_nxt inside {MEM_SR, PWR_OFF} || deep_rest;
  // power goes last, so memory is already self-refreshing when it drops
  wire power_off_nxt = state_nxt == PWR_OFF || deep_rest;
  // context survives in the light type and whenever the system works
  wire context_keep_nxt = light_nxt || state_nxt == WORKING;
  wire sleeping_nxt = state_nxt != WORKING; // raised through resume too

  // plane control registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cpu_halt <= 1'b0;
      clocks_stop <= 1'b0;
      mem_self_refresh <= 1'b0;
      power_off <= 1'b0;
      context_keep <= 1'b1;
      sleeping <= 1'b0;
    end
    else
    begin
      cpu_halt <= cpu_halt_nxt;
      clocks_stop <= clocks_stop_nxt;
      mem_self_refresh <= mem_sr_nxt;
      power_off <= power_off_nxt;
      context_keep <= context_keep_nxt;
      sleeping <= sleeping_nxt;
    end
  end

  // firmware hibernate request pulse
  always_ff @(posedge mclk)
  begin
    if (reset)
      fw_hibernate <= 1'b0;
    else
      fw_hibernate <= hib_pulse;
  end

  // events: set wins over read-clear
  assign events[sleep_pkg::ST_WAKE] = state_r == ASLEEP;
  assign events[sleep_pkg::ST_SLEPT] = state_r == HALT && step_done;
  assign events[sleep_pkg::ST_FW_HIB] = hib_pulse;
  // bits the finishing status read handed out, and only those
  wire [sleep_pkg::ST_W-1:0] rd_clear = st_rd ? rdata_r[sleep_pkg::ST_W-1:0] : '0;

  // status and mask
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      status_r <= '0;
      mask_r <= '0;
    end
    else
    begin
      // clear only what the read returned; an event that landed while
      // the read was waiting stays set for the next read
      status_r <= (status_r & ~rd_clear) | events;
      if (wr_mk)
        mask_r <= avs_writedata[sleep_pkg::ST_W-1:0];
    end
  end

  // level interrupt straight from two registers, so it cannot glitch
  assign irq = |(status_r & mask_r);

  // read data; the enable bit always reads zero
  always_comb
  begin
    rd_mux = '0; // unmapped offsets read zero
    if (sel_a)
      rd_mux = sleep_pkg::DATA_W'(type_a_r) << sleep_pkg::TYPE_LSB;
    else if (sel_b)
      rd_mux = sleep_pkg::DATA_W'(type_b_r) << sleep_pkg::TYPE_LSB;
    else if (sel_st)
      rd_mux = sleep_pkg::DATA_W'(status_r);
    else if (sel_mk)
      rd_mux = sleep_pkg::DATA_W'(mask_r);
  end

  // reads take one wait cycle, writes none; the word is captured in the
  // wait cycle and stands until the next read, which costs one cycle of
  // latency but keeps the read data straight from a flip-flop
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rd_ack_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      rd_ack_r <= avs_read && !rd_ack_r;
      if (avs_read && !rd_ack_r)
        rdata_r <= rd_mux;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = avs_read && !rd_ack_r;
  assign target_type_a = type_a_r;
  assign target_type_b = type_b_r;
endmodule // sleep_state_control

/* File: sleep_state_control_asserts.sv */
// port checker for the sleep state control block
`timescale 1ns/1ns
module sleep_state_control_asserts #(
  parameter int N_WAKE = 8,
  parameter logic [7:0] HIB_REQ_VALUE = 8'h5a
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [sleep_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [sleep_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [sleep_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic cmd_port_write,
  input wire logic [7:0] cmd_port_data,
  input wire logic prepare_to_sleep,
  input wire logic [N_WAKE-1:0] wake_enable,
  input wire logic [N_WAKE-1:0] wake_source,
  input wire logic [sleep_pkg::TYPE_W-1:0] target_type_a,
  input wire logic cpu_halt,
  input wire logic clocks_stop,
  input wire logic power_off,
  input wire logic context_keep,
  input wire logic fw_hibernate,
  input wire logic sleeping
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // trigger write to instance a, only honoured while awake
  wire go = avs_write && avs_byteenable[1] && avs_writedata[sleep_pkg::ENABLE_BIT] && !sleeping
    && avs_address == sleep_pkg::OFF_CTRL_A;
  wire rd_done = avs_read && !avs_waitrequest; // read answer cycle
  // long enough in light sleep for the halt step to be over
  sequence light_rest;
    (sleeping && target_type_a == sleep_pkg::TYPE_LIGHT)[*8];
  endsequence
  AST_SLEEP_GO:
    assert property (go |=> sleeping && cpu_halt) else $error("sleep did not start");
  AST_TYPE_A:
    assert property (go |=> target_type_a ==
      $past(avs_writedata[sleep_pkg::TYPE_LSB +: sleep_pkg::TYPE_W])) else $error("type lost");
  AST_TRIGGER_RD0:
    assert property (rd_done && avs_address == sleep_pkg::OFF_CTRL_A |-> !avs_readdata[13])
      else $error("trigger bit reads one");
  AST_PTS_IDLE:
    assert property (prepare_to_sleep && !sleeping && !avs_write |=> !sleeping)
      else $error("sleep on prepare");
  AST_LIGHT_KEEP:
    assert property (sleeping && target_type_a == sleep_pkg::TYPE_LIGHT |->
      context_keep && !clocks_stop && !power_off) else $error("light sleep lost context");
  // cycles spent asleep with no enabled raw wake input; the limit covers
  // the synchroniser and the resume dwell with room to spare
  localparam logic [4:0] QUIET_MIN = 5'h10;
  logic [4:0] quiet_r;
  always_ff @(posedge mclk)
  begin
    if (reset || !sleeping || (|(wake_source & wake_enable)))
      quiet_r <= '0;
    else if (quiet_r != 5'h1f)
      quiet_r <= quiet_r + 5'h01;
  end
  AST_NO_WAKE:
    assert property (quiet_r >= QUIET_MIN |-> sleeping)
      else $error("woke without enabled source");
  AST_WAKE_ST:
    assert property (light_rest ##1 (rd_done && avs_address == sleep_pkg::OFF_STATUS) |->
      avs_readdata[sleep_pkg::ST_WAKE]) else $error("wake status clear in sleep");
  AST_HIB_PULSE:
    assert property (cmd_port_write && cmd_port_data == HIB_REQ_VALUE && !sleeping |=>
      fw_hibernate ##1 !fw_hibernate) else $error("hibernate pulse wrong");
endmodule // sleep_state_control_asserts
bind sleep_state_control sleep_state_control_asserts #(
  .N_WAKE(N_WAKE),
  .HIB_REQ_VALUE(HIB_REQ_VALUE)
) u_sleep_state_control_asserts (
  .mclk(mclk),
  .reset(reset),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .cmd_port_write(cmd_port_write),
  .cmd_port_data(cmd_port_data),
  .prepare_to_sleep(prepare_to_sleep),
  .wake_enable(wake_enable),
  .wake_source(wake_source),
  .target_type_a(target_type_a),
  .cpu_halt(cpu_halt),
  .clocks_stop(clocks_stop),
  .power_off(power_off),
  .context_keep(context_keep),
  .fw_hibernate(fw_hibernate),
  .sleeping(sleeping)
);

/* File: test_sleep_state_control.sv */
// self-checking bench for the sleep state control block
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_sleep_state_control;
  int num_errors = 0;
  int n_compared = 0;
  logic mclk = 0;
  logic reset = 1;
  logic avs_read = 0;
  logic avs_write = 0;
  logic cmd_port_write = 0;
  logic prepare_to_sleep = 0;
  logic [3:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic [7:0] cmd_port_data = 8'h00;
  logic [7:0] wake_enable = 8'h01; // only source 0 may wake
  logic [7:0] wake_source = 8'h00;
  logic [31:0] avs_readdata, q;
  logic [2:0] target_type_a, target_type_b;
  logic avs_waitrequest, cpu_halt, clocks_stop, mem_self_refresh, power_off;
  logic context_keep, fw_hibernate, sleeping, irq;
  sleep_state_control u_sleep_state_control (
    .mclk(mclk),
    .reset(reset),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .cmd_port_write(cmd_port_write),
    .cmd_port_data(cmd_port_data),
    .prepare_to_sleep(prepare_to_sleep),
    .wake_enable(wake_enable),
    .wake_source(wake_source),
    .target_type_a(target_type_a),
    .target_type_b(target_type_b),
    .cpu_halt(cpu_halt),
    .clocks_stop(clocks_stop),
    .mem_self_refresh(mem_self_refresh),
    .power_off(power_off),
    .context_keep(context_keep),
    .fw_hibernate(fw_hibernate),
    .sleeping(sleeping),
    .irq(irq)
  );
  always #50 mclk = ~mclk;
  // one bus cycle; holds the request until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata; // taken at the edge that sees waitrequest low
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge mclk); // let the taking edge's updates land
  endtask
  // waits for sleeping to reach v, bounded
  task hold(input logic v);
    for (int i = 0; i < 300 && sleeping !== v; i++) @(negedge mclk);
  endtask
  task print_verdict;
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // light state: halted, context kept, only the enabled source wakes
  task t_light;
    bus(1, sleep_pkg::OFF_MASK, 32'h7);
    bus(1, sleep_pkg::OFF_CTRL_A, 32'h2400); // caches taken as flushed
    hold(1);
    repeat (20) @(negedge mclk);
    `CHK("halt", 1'h1, cpu_halt)
    `CHK("keep", 3'b100, {context_keep, clocks_stop, power_off})
    `CHK("type", 3'h1, target_type_a)
    bus(0, sleep_pkg::OFF_CTRL_A, 0);
    `CHK("ctrl rd", 32'h0400, q)
    bus(0, sleep_pkg::OFF_STATUS, 0);
    `CHK("wake st", 2'b11, q[1:0])
    @(posedge mclk);
    wake_source <= 8'h02;
    repeat (20) @(negedge mclk);
    `CHK("no wake", 1'h1, sleeping)
    @(posedge mclk);
    wake_source <= 8'h01; // alarm stands in as the enabled source
    hold(0);
    `CHK("awake", 1'b0, sleeping)
    @(posedge mclk);
    wake_source <= 8'h00;
  endtask
  // deep state: both instances loaded, plane sequence runs
  task t_deep;
    bus(1, sleep_pkg::OFF_CTRL_B, 32'h1800);
    `CHK("b no go", 1'b0, sleeping)
    bus(1, sleep_pkg::OFF_CTRL_A, 32'h3400);
    `CHK("type b", 3'h6, target_type_b)
    `CHK("type a", 3'h5, target_type_a)
    for (int i = 0; i < 100 && power_off !== 1; i++) @(negedge mclk);
    `CHK("planes", 3'b111, {clocks_stop, mem_self_refresh, power_off})
    @(posedge mclk);
    wake_source <= 8'h01;
    hold(0);
    `CHK("resumed", 2'b00, {power_off, cpu_halt})
    @(posedge mclk);
    wake_source <= 8'h00;
  endtask
  // prepare-to-sleep does nothing; hibernate command gives a status event
  task t_hib;
    bus(0, sleep_pkg::OFF_STATUS, 0);
    @(posedge mclk);
    prepare_to_sleep <= 1;
    cmd_port_write <= 1;
    cmd_port_data <= 8'h5a;
    @(posedge mclk);
    cmd_port_write <= 1'h0;
    @(negedge mclk);
    `CHK("hib pulse", 1'h1, fw_hibernate)
    @(negedge mclk);
    `CHK("hib end", 1'h0, fw_hibernate)
    repeat (8) @(negedge mclk);
    `CHK("pts idle", 1'b0, sleeping)
    `CHK("irq", 1'b1, irq)
    bus(0, sleep_pkg::OFF_STATUS, 0);
    `CHK("hib st", 32'h4, q)
    bus(0, sleep_pkg::OFF_STATUS, 0);
    `CHK("cleared", 2'b00, {q[2], irq})
    bus(0, 4'h2, 0);
    `CHK("unmapped", 32'h0, q)
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    reset <= 0;
    @(negedge mclk);
    `CHK("reset", 3'b100, {context_keep, sleeping, irq})
    t_light;
    t_deep;
    t_hib;
    print_verdict;
  end
  // hang guard, well past the expected run length
  initial
  begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    print_verdict;
  end
endmodule // test_sleep_state_control

/* File: wake_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module wake_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r; // first stage, read only by s2_r
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  // shift chain; a change counts once stage two and three agree
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      dout <= (s2_r & s3_r) | (dout & (s2_r | s3_r));
    end
  end
endmodule // wake_sync
